// [src/lbd_pkg.sv]
// Purpose: shared constants and types for the led brightness dimming pwm block
// Assumes: 10 MHz system clock standing in for the dimming oscillator
// Notes: frequency codes index the frequency table; mode codes are in gray order, so current and direct swap against the strap order
package lbd_pkg;
	localparam int unsigned LBD_CLK_HZ = 10_000_000;
	localparam int unsigned LBD_CLK_PERIOD_NS = 100;
	localparam int unsigned LBD_FREQ_HZ [8] = '{152, 305, 610, 1221, 2441, 4883, 9766, 19531};
	localparam logic [2:0] LBD_FREQ_DEFAULT = 3'h1;
	localparam int unsigned LBD_MIN_FREQ_HZ = 152;
	localparam int unsigned LBD_MIN_PULSE_NS = 200;
	localparam int unsigned LBD_MIN_PULSE_CYC = (LBD_MIN_PULSE_NS + LBD_CLK_PERIOD_NS - 1) / LBD_CLK_PERIOD_NS;
	localparam int unsigned LBD_SLOPE_BASE_MS = 50;
	localparam int unsigned LBD_SLOPE_BASE_CYC = LBD_SLOPE_BASE_MS * (LBD_CLK_HZ / 1000);
	localparam logic [15:0] LBD_HYST_LSB = 16'h007d;
	localparam logic [15:0] LBD_HYBRID_KNEE = 16'h2000;
	localparam int unsigned LBD_HYBRID_SHIFT = 3;
	localparam logic [3:0] LBD_DITHER_MAX = 4'h4;
	localparam logic [2:0] LBD_STRINGS_DEFAULT = 3'h6;
	localparam int unsigned LBD_PW = 24;
	typedef enum logic [1:0] {
		LBD_M_PHASE = 2'b00,
		LBD_M_HYBRID = 2'b01,
		LBD_M_CURRENT = 2'b11,
		LBD_M_DIRECT = 2'b10
	} lbd_mode_t;
	typedef struct packed {
		logic [2:0] code;
		logic valid;
	} lbd_strap_t;
	typedef struct packed {
		lbd_mode_t mode;
		logic addr_alt;
		logic [2:0] freq_code;
		logic [2:0] strings;
		logic mode_fault;
		logic fset_fault;
	} lbd_cfg_t;
endpackage

// [src/lbd_chan.sv]
// Purpose: one led sink channel, phase shifted against the shared period counter
// Assumes: offset below period, width latched by the parent at period start
// Notes: output registered so every channel lags the counter by one cycle
`timescale 1ns/1ps
`default_nettype none
module lbd_chan
	import lbd_pkg::*;
#(
	parameter int unsigned PW = LBD_PW
)(
	input wire logic clock,
	input wire logic srst,
	input wire logic ce,
	input wire logic [PW-1:0] cnt,
	input wire logic [PW-1:0] period,
	input wire logic [PW-1:0] offset,
	input wire logic [PW-1:0] width,
	input wire logic enable,
	input wire logic direct,
	input wire logic pin,
	output logic on
);
	logic [PW-1:0] phased;

	assign phased = (cnt >= offset) ? cnt - offset : cnt + period - offset;

	always_ff @(posedge clock)
	begin
		if (srst)
			on <= 1'b0;
		else if (ce)
			on <= enable & (direct ? pin : (phased < width));
	end
endmodule
`default_nettype wire

// [src/lbd_pwm.sv]
// Purpose: brightness path and led pwm generation for a six channel backlight driver
// Assumes: straps and control ports synchronous to clock; srst is the power cycle
// Notes: one clock-enable freezes every flip-flop
// Summary of operation
// - led period comes from the internal clock; eight selectable frequencies 152 Hz to 19.531 kHz.
// - frequency strap code picks the frequency once at start-up.
// - phase-shift and hybrid periods run free of the input pwm pin.
// - source select picks pin duty or register brightness; pin after power-on.
// - mode strap picks dimming mode and target address from eight codes.
// - phase-shift mode switches each active channel once per period, fixed spacing.
// - neighbour offset is one period divided by number of active strings.
// - hybrid uses pwm below knee, current above; knee 12.5% or 0%.
// - hybrid low range scales duty by eight for eightfold dimming ratio.
// - direct pwm mode channels follow the input pin edges.
// - three-bit slope select sets transition time; zero disables sloper.
// - smooth curve enable adds perceptual shaping on top of linear slope.
// - outside direct mode, pin duty changes of 0.19% or less are ignored.
// - undithered brightness steps equal clock cycles per led period.
// - dither select gives off or 1 to 4 dither bits; off at reset.
// - one-bit dither lengthens every second pulse by one clock.
// - three-bit dither lengthens dither-value pulses out of each eight.
// - pulses shorter than minimum width are skipped and accumulated.
// - skipping never drops effective led rate below 152 Hz.
// - missing mode strap falls back to phase-shift with alternate address.
// - missing frequency strap falls back to 305 Hz, never re-read.
`timescale 1ns/1ps
`default_nettype none
module lbd_pwm
	import lbd_pkg::*;
#(
	parameter int unsigned CLK_HZ = LBD_CLK_HZ,
	parameter int unsigned SLOPE_BASE_CYC = LBD_SLOPE_BASE_CYC,
	parameter int unsigned NUM_CH = 6
)(
	input wire logic clock,
	input wire logic srst,
	input wire logic ce,
	input wire logic pwm_in,
	input wire lbd_strap_t mode_strap,
	input wire lbd_strap_t dim_freq_resistor_input,
	input wire logic [2:0] strings_cfg,
	input wire logic brightness_source_select,
	input wire logic [15:0] display_brightness_value,
	input wire logic [2:0] slope_select,
	input wire logic smooth_curve_enable,
	input wire logic [3:0] dither_select,
	input wire logic hybrid_knee_zero,
	output logic [NUM_CH-1:0] led_on,
	output logic [11:0] led_current,
	output lbd_cfg_t cfg,
	output logic [15:0] applied_brightness
);
	import lbd_pkg::*;

	localparam int unsigned PW = LBD_PW;
	localparam logic [PW-1:0] MIN_W = PW'(LBD_MIN_PULSE_CYC);
	localparam logic [PW-1:0] PERIOD_SLOW = PW'(CLK_HZ / LBD_MIN_FREQ_HZ);

	logic init_done;
	lbd_mode_t strap_mode;
	logic [2:0] strap_strings;
	logic [PW-1:0] period;
	logic [PW-1:0] skip_lim;
	logic [PW-1:0] offs [NUM_CH];
	logic [PW-1:0] cnt;
	logic [3:0] frame;
	logic period_end;

	// start-up capture: straps are read once and held until the next srst
	always_comb
	begin
		unique case (mode_strap.code[1:0])
			2'd0: strap_mode = LBD_M_PHASE;
			2'd1: strap_mode = LBD_M_HYBRID;
			2'd2: strap_mode = LBD_M_CURRENT;
			2'd3: strap_mode = LBD_M_DIRECT;
		endcase
		strap_strings = (strings_cfg >= 3'h1 && strings_cfg <= LBD_STRINGS_DEFAULT) ? strings_cfg : LBD_STRINGS_DEFAULT;
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			init_done <= 1'b0;
			cfg <= '0;
		end
		else if (ce && !init_done)
		begin
			init_done <= 1'b1;
			cfg.mode <= mode_strap.valid ? strap_mode : LBD_M_PHASE;
			cfg.addr_alt <= mode_strap.valid ? mode_strap.code[2] : 1'b1;
			cfg.mode_fault <= !mode_strap.valid;
			cfg.freq_code <= dim_freq_resistor_input.valid ? dim_freq_resistor_input.code : LBD_FREQ_DEFAULT;
			cfg.fset_fault <= !dim_freq_resistor_input.valid;
			cfg.strings <= strap_strings;
		end
	end

	// derived timing, settled one cycle after capture; counters wait for it
	logic cfg_ready;
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			cfg_ready <= 1'b0;
			period <= '0;
			skip_lim <= '0;
		end
		else if (ce && init_done && !cfg_ready)
		begin
			cfg_ready <= 1'b1;
			period <= PW'(CLK_HZ / LBD_FREQ_HZ[cfg.freq_code]);
			skip_lim <= PW'(CLK_HZ / LBD_FREQ_HZ[cfg.freq_code]) == '0 ? '0 :
				PW'(PERIOD_SLOW / PW'(CLK_HZ / LBD_FREQ_HZ[cfg.freq_code]) - 1);
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++)
		begin : g_off
			always_ff @(posedge clock)
			begin
				if (srst)
					offs[gi] <= '0;
				else if (ce && init_done && !cfg_ready)
					offs[gi] <= PW'((CLK_HZ / LBD_FREQ_HZ[cfg.freq_code]) * gi / cfg.strings);
			end
		end
	endgenerate

	// free-running period counter, never touched by the pin
	assign period_end = (cnt == period - PW'(1));
	always_ff @(posedge clock)
	begin
		if (srst || !cfg_ready)
		begin
			cnt <= '0;
			frame <= '0;
		end
		else if (ce)
		begin
			cnt <= period_end ? '0 : cnt + PW'(1);
			if (period_end)
				frame <= frame + 4'h1;
		end
	end

	// pin duty meter; a stuck pin saturates and reads as 0% or 100%
	logic pin_prev;
	logic [PW-1:0] hi_cnt, tot_cnt;
	logic [15:0] pin_duty, pin_held, pin_diff;
	logic [39:0] quot;
	assign quot = {hi_cnt, 16'h0} / {16'h0, tot_cnt};
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			pin_prev <= 1'b0;
			hi_cnt <= '0;
			tot_cnt <= '0;
			pin_duty <= '0;
		end
		else if (ce)
		begin
			pin_prev <= pwm_in;
			if (pwm_in && !pin_prev)
			begin
				pin_duty <= (tot_cnt == '0) ? 16'h0 : (quot > 40'h0ffff ? 16'hffff : quot[15:0]);
				hi_cnt <= PW'(1);
				tot_cnt <= PW'(1);
			end
			else if (&tot_cnt)
				pin_duty <= pin_prev ? 16'hffff : 16'h0;
			else
			begin
				tot_cnt <= tot_cnt + PW'(1);
				hi_cnt <= hi_cnt + PW'(pwm_in);
			end
		end
	end

	// hysteresis: small jitter from slow board edges must not move the output
	assign pin_diff = (pin_duty > pin_held) ? pin_duty - pin_held : pin_held - pin_duty;
	always_ff @(posedge clock)
	begin
		if (srst)
			pin_held <= '0;
		else if (ce && (cfg.mode == LBD_M_DIRECT || pin_diff > LBD_HYST_LSB))
			pin_held <= pin_duty;
	end

	// source select and sloper
	logic [15:0] target;
	logic [31:0] slim;
	logic [PW-1:0] tick_lim, tick_cnt;
	assign target = brightness_source_select ? display_brightness_value : pin_held;
	assign slim = (32'(SLOPE_BASE_CYC) << (slope_select - 3'h1)) >> 16;
	assign tick_lim = (slim == 32'h0) ? PW'(1) : slim[PW-1:0];

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			applied_brightness <= '0;
			tick_cnt <= '0;
		end
		else if (ce)
		begin
			if (slope_select == 3'h0)
			begin
				applied_brightness <= target;
				tick_cnt <= '0;
			end
			else if (tick_cnt >= tick_lim - PW'(1))
			begin
				tick_cnt <= '0;
				if (applied_brightness < target)
					applied_brightness <= applied_brightness + 16'h1;
				else if (applied_brightness > target)
					applied_brightness <= applied_brightness - 16'h1;
			end
			else
				tick_cnt <= tick_cnt + PW'(1);
		end
	end

	// perceptual shaping: squaring gives fine steps near black
	logic [31:0] sq;
	logic [15:0] shaped, knee, duty;
	logic [11:0] next_current;
	assign sq = applied_brightness * applied_brightness;
	assign shaped = smooth_curve_enable ? sq[31:16] : applied_brightness;
	assign knee = hybrid_knee_zero ? 16'h0 : LBD_HYBRID_KNEE;

	always_comb
	begin
		duty = 16'hffff;
		next_current = 12'hfff;
		unique case (cfg.mode)
			LBD_M_PHASE: duty = shaped;
			LBD_M_HYBRID:
			begin
				if (shaped < knee)
				begin
					duty = shaped << LBD_HYBRID_SHIFT;
					next_current = knee[15:4];
				end
				else
					next_current = shaped[15:4];
			end
			LBD_M_CURRENT: next_current = shaped[15:4];
			LBD_M_DIRECT: next_current = 12'hfff;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			led_current <= '0;
		else if (ce)
			led_current <= next_current;
	end

	// dither and minimum pulse handling, latched once per period
	logic [39:0] prod;
	logic [2:0] dbits;
	logic [3:0] dval, rev;
	logic [PW-1:0] w_dith, acc_n, pulse_w, acc, skip;
	assign prod = 40'(duty) * 40'(period);
	assign dbits = (dither_select <= LBD_DITHER_MAX) ? dither_select[2:0] : 3'h0;
	assign dval = prod[15:12] >> (3'h4 - dbits);
	assign rev = {frame[0], frame[1], frame[2], frame[3]} >> (3'h4 - dbits);
	assign w_dith = (duty == 16'hffff) ? period : prod[39:16] + PW'(rev < dval);
	assign acc_n = acc + w_dith;

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			pulse_w <= '0;
			acc <= '0;
			skip <= '0;
		end
		else if (ce && period_end && cfg_ready)
		begin
			if (w_dith == '0)
			begin
				pulse_w <= '0;
				skip <= '0;
			end
			else if (w_dith < MIN_W)
			begin
				if (acc_n >= MIN_W || skip >= skip_lim)
				begin
					pulse_w <= MIN_W;
					acc <= (acc_n >= MIN_W) ? acc_n - MIN_W : '0;
					skip <= '0;
				end
				else
				begin
					pulse_w <= '0;
					acc <= acc_n;
					skip <= skip + PW'(1);
				end
			end
			else
			begin
				pulse_w <= w_dith;
				skip <= '0;
			end
		end
	end

	generate
		for (gi = 0; gi < NUM_CH; gi++)
		begin : g_ch
			lbd_chan #(.PW(PW)) u_chan (
				.clock(clock),
				.srst(srst),
				.ce(ce),
				.cnt(cnt),
				.period(period),
				.offset(offs[gi]),
				.width(pulse_w),
				.enable(cfg_ready && (gi < cfg.strings)),
				.direct(cfg.mode == LBD_M_DIRECT),
				.pin(pwm_in),
				.on(led_on[gi])
			);
		end
	endgenerate

	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	sequence s_capture;
		ce && !init_done;
	endsequence
	sequence s_wrap;
		ce && cfg_ready && period_end;
	endsequence

	AST_MODE_FALLBACK: assert property (s_capture ##0 !mode_strap.valid |=> cfg.mode == LBD_M_PHASE && cfg.addr_alt)
		else $error("missing mode strap did not fall back");
	AST_MODE_DECODE: assert property (s_capture ##0 mode_strap.valid |=> cfg.addr_alt == $past(mode_strap.code[2]))
		else $error("address select not taken from strap");
	AST_FSET_DEFAULT: assert property (s_capture ##0 !dim_freq_resistor_input.valid |=> cfg.freq_code == LBD_FREQ_DEFAULT)
		else $error("missing frequency strap did not default");
	AST_CFG_HELD: assert property (init_done |=> $stable(cfg))
		else $error("captured configuration changed");
	AST_FREE_RUN: assert property (s_wrap |=> cnt == '0)
		else $error("period counter did not wrap at period end");
	AST_HYST: assert property (ce && cfg.mode != LBD_M_DIRECT && pin_diff <= LBD_HYST_LSB |=> $stable(pin_held))
		else $error("small pin duty change passed hysteresis");
	AST_NO_SLOPE: assert property (ce && slope_select == 3'h0 |=> applied_brightness == $past(target))
		else $error("sloper off but brightness did not jump");
	AST_SLOPE_STEP: assert property (ce && slope_select != 3'h0 && applied_brightness < target
		|=> applied_brightness - $past(applied_brightness) <= 16'h1)
		else $error("slope step larger than one");
	AST_DIRECT: assert property (ce && cfg_ready && cfg.mode == LBD_M_DIRECT && cfg.strings != 3'h0
		|=> led_on[0] == $past(pwm_in))
		else $error("direct mode channel did not follow pin");
	AST_HYB_LOW: assert property (cfg.mode == LBD_M_HYBRID && shaped < knee ##0 ce |=> led_current == $past(knee[15:4]))
		else $error("hybrid low range current not at knee");
	AST_SKIP_BOUND: assert property (cfg_ready |-> skip <= skip_lim)
		else $error("pulse skipping ran below minimum rate");
	AST_MIN_PULSE: assert property (s_wrap ##1 pulse_w != '0 |-> pulse_w >= MIN_W)
		else $error("pulse shorter than minimum width");
endmodule
`default_nettype wire

// [src/lbd_pwm_end.sv]
// Purpose: closing file of the dimming block sources
// Assumes: read after the other design files
// Notes: holds no code of its own
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [bench/lbd_host.sv]
// Purpose: host side pwm source for the brightness pin
// Assumes: total and high are changed by the bench between tests and also within tests
// Notes: new duty taken at frame wrap so every frame is steady
`timescale 1ns/1ps
`default_nettype none
module lbd_host (
	input wire logic clock,
	input wire logic srst,
	input wire logic [15:0] total,
	input wire logic [15:0] high,
	output logic pwm_in
);
	logic [15:0] cnt = 16'h0;
	logic [15:0] cur_high = 16'h0;
	initial pwm_in = 1'b0;
	always @(posedge clock)
	begin
		if (srst || cnt >= total - 16'h1)
		begin
			cnt <= 16'h0;
			cur_high <= high;
		end
		else
		begin
			cnt <= cnt + 16'h1;
		end
		pwm_in <= !srst && (cnt < cur_high);
	end
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// Purpose: self-checking bench for the brightness and led pwm path
// Assumes: scaled clock rate so the 19.5 kHz period is ten cycles
// Notes: outputs sampled on the falling edge, inputs driven on the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import lbd_pkg::*;
	localparam int unsigned SIM_HZ = 200000;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic pwm_in;
	lbd_strap_t mode_strap = '{3'h0, 1'b1};
	lbd_strap_t fset = '{3'h7, 1'b1};
	logic [2:0] strings_cfg = 3'h6;
	logic src_sel = 1'b0;
	logic [15:0] disp_val = 16'h0;
	logic [2:0] slope_select = 3'h0;
	logic smooth = 1'b0;
	logic knee0 = 1'b0;
	logic [3:0] dith = 4'h0;
	logic [15:0] h_total = 16'd1000;
	logic [15:0] h_high = 16'd500;
	logic [5:0] led_on;
	logic [11:0] led_current;
	lbd_cfg_t cfg;
	logic [15:0] applied;
	int miscompares = 0;
	int compares = 0;
	int cycles = 0;
	always #50 clock = ~clock;
	lbd_host u_lbd_host (.clock(clock), .srst(srst), .total(h_total), .high(h_high), .pwm_in(pwm_in));
	lbd_pwm #(.CLK_HZ(SIM_HZ), .SLOPE_BASE_CYC(131072), .NUM_CH(6)) u_lbd_pwm (
		.clock(clock), .srst(srst), .ce(1'b1), .pwm_in(pwm_in), .mode_strap(mode_strap),
		.dim_freq_resistor_input(fset), .strings_cfg(strings_cfg), .brightness_source_select(src_sel),
		.display_brightness_value(disp_val), .slope_select(slope_select), .smooth_curve_enable(smooth),
		.dither_select(dith), .hybrid_knee_zero(knee0), .led_on(led_on), .led_current(led_current),
		.cfg(cfg), .applied_brightness(applied)
	);
	task automatic complete_run();
		if (miscompares == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 60000)
		begin
			miscompares++;
			complete_run();
		end
	end
	task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check_cfg(input string what, input lbd_cfg_t exp, input lbd_cfg_t got);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic do_reset(input logic [3:0] ms, input logic [3:0] fs, input logic [2:0] st);
		@(posedge clock);
		srst <= 1'b1;
		mode_strap <= ms;
		fset <= fs;
		strings_cfg <= st;
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		cyc(4);
	endtask
	task automatic set_reg(input logic [15:0] v, input logic [2:0] sl, input logic sm);
		@(posedge clock);
		src_sel <= 1'b1;
		disp_val <= v;
		slope_select <= sl;
		smooth <= sm;
	endtask
	// straps missing: fallback kept even when straps appear later
	task automatic test_fallback();
		do_reset({3'h2, 1'b0}, {3'h6, 1'b0}, 3'h7);
		check_cfg("cfg_fault", '{LBD_M_PHASE, 1'b1, 3'h1, 3'h6, 1'b1, 1'b1}, cfg);
		check_val("reset_brightness", 16'h0, applied);
		@(posedge clock);
		mode_strap <= '{3'h3, 1'b1};
		fset <= '{3'h0, 1'b1};
		cyc(20);
		check_cfg("cfg_kept", '{LBD_M_PHASE, 1'b1, 3'h1, 3'h6, 1'b1, 1'b1}, cfg);
	endtask
	// two strings at top frequency: offset is half the period
	task automatic test_phase();
		int per;
		int gap;
		per = SIM_HZ / LBD_FREQ_HZ[7];
		do_reset({3'h4, 1'b1}, {3'h7, 1'b1}, 3'h2);
		check_cfg("cfg_phase", '{LBD_M_PHASE, 1'b1, 3'h7, 3'h2, 1'b0, 1'b0}, cfg);
		set_reg(16'h8000, 3'h0, 1'b0);
		cyc(5 * per);
		check_val("reg_brightness", 16'h8000, applied);
		check_val("phase_current", 16'h0fff, {4'h0, led_current});
		gap = 0;
		while (led_on[0] !== 1'b1 && gap < 4 * per)
		begin
			cyc(1);
			gap++;
		end
		while (led_on[0] === 1'b1 && gap < 4 * per)
		begin
			cyc(1);
			gap++;
		end
		gap = 0;
		while (led_on[0] !== 1'b1 && gap < 4 * per)
		begin
			cyc(1);
		end
		while (led_on[1] !== 1'b1 && gap < 4 * per)
		begin
			cyc(1);
			gap++;
		end
		check_val("phase_offset", 16'(per / 2), 16'(gap));
		check_val("unused_off", 16'h0, {12'h0, led_on[5:2]});
	endtask
	// pin source: small duty change ignored, large change followed
	task automatic test_hyst();
		logic [15:0] base;
		do_reset({3'h0, 1'b1}, {3'h7, 1'b1}, 3'h6);
		@(posedge clock);
		src_sel <= 1'b0;
		slope_select <= 3'h0;
		h_high <= 16'd500;
		cyc(4000);
		base = applied;
		check_val("pin_half", 16'h1, {15'h0, base > 16'h7e00 && base < 16'h8200});
		@(posedge clock);
		h_high <= 16'd501;
		cyc(3000);
		check_val("pin_small", base, applied);
		@(posedge clock);
		h_high <= 16'd520;
		cyc(3000);
		check_val("pin_large", 16'h1, {15'h0, applied > base});
	endtask
	// sloper ramps up step by step instead of jumping
	task automatic test_slope();
		logic [15:0] prev;
		set_reg(16'h0, 3'h0, 1'b0);
		cyc(5);
		check_val("slope_off", 16'h0, applied);
		set_reg(16'h1000, 3'h1, 1'b0);
		prev = 16'h0;
		repeat (40)
		begin
			cyc(1);
			check_val("slope_mono", 16'h1, {15'h0, applied >= prev});
			prev = applied;
		end
		check_val("slope_mid", 16'h1, {15'h0, applied > 16'h0 && applied < 16'h1000});
	endtask
	// current mode amplitude and the perceptual curve
	task automatic test_current();
		do_reset({3'h2, 1'b1}, {3'h5, 1'b1}, 3'h3);
		check_cfg("cfg_current", '{LBD_M_CURRENT, 1'b0, 3'h5, 3'h3, 1'b0, 1'b0}, cfg);
		set_reg(16'h8000, 3'h0, 1'b0);
		cyc(10);
		check_val("cur_linear", 16'h0800, {4'h0, led_current});
		set_reg(16'h8000, 3'h0, 1'b1);
		cyc(10);
		check_val("cur_smooth", 16'h0400, {4'h0, led_current});
	endtask
	task automatic sync_rise();
		int w;
		w = 0;
		while (led_on[0] === 1'b1 && w < 400)
		begin
			cyc(1);
			w++;
		end
		while (led_on[0] !== 1'b1 && w < 400)
		begin
			cyc(1);
			w++;
		end
	endtask
	task automatic count_high(input int n, output int h);
		h = 0;
		sync_rise();
		repeat (n)
		begin
			h += int'(led_on[0] === 1'b1);
			cyc(1);
		end
	endtask
	// hybrid: low range runs pwm at eight times duty with current at the knee
	task automatic test_hybrid();
		int h;
		do_reset({3'h1, 1'b1}, {3'h7, 1'b1}, 3'h6);
		check_cfg("cfg_hybrid", '{LBD_M_HYBRID, 1'b0, 3'h7, 3'h6, 1'b0, 1'b0}, cfg);
		set_reg(16'h1000, 3'h0, 1'b0);
		cyc(30);
		check_val("hyb_knee_current", 16'h0200, {4'h0, led_current});
		count_high(10, h);
		check_val("hyb_low_width", 16'd5, 16'(h));
		@(posedge clock);
		knee0 <= 1'b1;
		cyc(5);
		check_val("hyb_knee_zero", 16'h0100, {4'h0, led_current});
		@(posedge clock);
		knee0 <= 1'b0;
	endtask
	// dither spreads the fraction; short pulses merge into minimum width
	task automatic test_dither();
		int h;
		do_reset({3'h0, 1'b1}, {3'h7, 1'b1}, 3'h6);
		set_reg(16'h4000, 3'h0, 1'b0);
		cyc(30);
		count_high(20, h);
		check_val("dith_off", 16'd4, 16'(h));
		@(posedge clock);
		dith <= 4'h1;
		cyc(30);
		count_high(20, h);
		check_val("dith_one", 16'd5, 16'(h));
		set_reg(16'h4c00, 3'h0, 1'b0);
		@(posedge clock);
		dith <= 4'h3;
		cyc(30);
		count_high(80, h);
		check_val("dith_three", 16'd23, 16'(h));
		set_reg(16'h1000, 3'h0, 1'b0);
		@(posedge clock);
		dith <= 4'h4;
		cyc(60);
		sync_rise();
		h = 0;
		while (led_on[0] === 1'b1 && h < 20)
		begin
			cyc(1);
			h++;
		end
		check_val("dith_min_pulse", 16'(LBD_MIN_PULSE_NS / LBD_CLK_PERIOD_NS), 16'(h));
		@(posedge clock);
		dith <= 4'h0;
	endtask
	// direct mode: channels copy the pin one cycle late
	task automatic test_direct();
		logic prev;
		do_reset({3'h7, 1'b1}, {3'h7, 1'b1}, 3'h6);
		check_cfg("cfg_direct", '{LBD_M_DIRECT, 1'b1, 3'h7, 3'h6, 1'b0, 1'b0}, cfg);
		@(posedge clock);
		src_sel <= 1'b0;
		h_total <= 16'd20;
		h_high <= 16'd7;
		cyc(2100);
		prev = pwm_in;
		repeat (60)
		begin
			cyc(1);
			check_val("direct_follow", {16{prev}} & 16'h003f, {10'h0, led_on});
			prev = pwm_in;
		end
	endtask
	initial
	begin
		cyc(3);
		test_fallback();
		test_phase();
		test_hyst();
		test_slope();
		test_current();
		test_hybrid();
		test_dither();
		test_direct();
		complete_run();
	end
endmodule
`default_nettype wire
